// ==== rtl/dfmc_core.sv ====
// Command interpreter for Service, Set Features and Set Max Address.
// Assumes the host writes task-file inputs before the command strobe
// and only while busy is low; pins cross in through four flip-flops.
//
// Functional notes
// - Service resumes released command, drive-select only.
// - Undefined feature code sets abort bit.
// - AAh enables, 55h disables read look-ahead.
// - 05h enables, 85h disables power management.
// - 44h selects 40 ECC bytes, BBh four.
// - Hard reset restores cache, ECC, look-ahead defaults.
// - Transfer selector: five type, three mode bits.
// - PIO default, no-ready, flow-control modes 0-4.
// - Multiword DMA 0-2, Ultra DMA 0-5 accepted.
// - Full reassignment forces write cache off.
// - Power level from sector count; ranges abort.
// - Low idle unloads heads; low RPM 60-65%.
// - Power management off makes idle deepest.
// - Acoustic levels: FF/00-7F abort, else seek.
// - Acoustic settings survive every reset but power-on.
// - F9h sets max only after native read.
// - Beyond new limit aborts; identify reports limit.
// - Offset mode aborts nonvolatile max set.
// - Second nonvolatile set aborts until hard reset.
// - Locked or frozen state aborts max set.
// - Option bit chooses persistent or volatile limit.
// - Locked rejects all but unlock, freeze-lock.
`timescale 1ns/1ns
`include "dfmc_regs.svh"
module dfmc_core
   import dfmc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        soft_rst_in,
   input  wire logic        por_in,
   input  wire logic        cmd_wr_in,
   input  wire logic [7:0]  cmd_in,
   input  wire logic [7:0]  feature_in,
   input  wire logic [7:0]  sector_count_in,
   input  wire logic [7:0]  sector_number_in,
   input  wire logic [7:0]  cyl_low_in,
   input  wire logic [7:0]  cyl_high_in,
   input  wire logic [7:0]  drive_and_head_select_in,
   input  wire logic        reassign_full_pin_in,
   input  wire logic        access_chk_in,
   input  wire logic [27:0] access_lba_in,
   input  wire logic        released_pending_in,
   output logic [7:0]       error_flags_out,
   output logic [7:0]       status_flags_out,
   output logic [7:0]       drive_and_head_select_out,
   output logic             service_req_out,
   output logic             access_abort_out,
   output logic [27:0]      max_lba_out,
   output logic             write_cache_out,
   output logic             read_ahead_out,
   output logic             ecc40_out,
   output logic             revert_defaults_out,
   output logic             release_irq_out,
   output logic             no_ready_out,
   output logic [7:0]       xfer_mode_out,
   output logic             power_level_control_out,
   output dfmc_pwr_type     deepest_power_out,
   output logic             heads_unload_out,
   output logic [6:0]       spindle_pct_out,
   output logic             acoustic_level_control_out,
   output logic             quiet_seek_out,
   output logic             address_offset_out,
   output logic             standby_powerup_out,
   output dfmc_max_type     max_state_out
);
   logic        reassign_full;
   logic        xfer_valid;
   logic        xfer_no_ready;
   logic        abort_d;
   logic        native_seen_q;
   logic        nv_done_q;
   logic        wc_req_q;
   logic        is_lba;
   logic [27:0] req_lba;
   logic        fe_cmd;
   logic        max_cmd;
   logic        max_set;
   logic [7:0]  sc;
   // ---------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------
   dfmc_sync u_sync
   (
      .clk_in    (clk_in),
      .rst_b_in  (rst_b_in),
      .pin_in    (reassign_full_pin_in),
      .level_out (reassign_full)
   );
   dfmc_xfer_decode u_xfer
   (
      .sel_in       (sector_count_in),
      .valid_out    (xfer_valid),
      .no_ready_out (xfer_no_ready)
   );
   // Command decode and requested address
   assign sc      = sector_count_in;
   assign fe_cmd  = cmd_wr_in && (cmd_in == `DFMC_CMD_SET_FEATURES);
   assign max_cmd = cmd_wr_in && (cmd_in == `DFMC_CMD_SET_MAX);
   assign max_set = max_cmd && native_seen_q;
   assign is_lba  = drive_and_head_select_in[`DFMC_DH_LBA_BIT];
   // LBA bytes from address registers, CHS takes cylinder and head
   assign req_lba = is_lba ?
      {drive_and_head_select_in[3:0], cyl_high_in, cyl_low_in, sector_number_in} :
      {drive_and_head_select_in[3:0], cyl_high_in, cyl_low_in, 8'h00};
   // ---------------------------------------------------------
   // Abort decision for the command being taken
   // ---------------------------------------------------------
   always_comb
   begin
      abort_d = 1'b0;
      if (fe_cmd)
      begin
         unique case (feature_in)
            `DFMC_FT_XFER:   abort_d = !xfer_valid;
            `DFMC_FT_PWR_ON: abort_d = (sc >= 8'hC0) || (sc <= 8'h3F);
            `DFMC_FT_ACU_ON: abort_d = (sc == 8'hFF) || (sc <= 8'h7F);
            `DFMC_FT_WC_ON, `DFMC_FT_PUIS_ON, `DFMC_FT_PUIS_SPN, `DFMC_FT_OFS_ON,
            `DFMC_FT_ECC40, `DFMC_FT_RLA_OFF, `DFMC_FT_RELI_ON, `DFMC_FT_REV_OFF,
            `DFMC_FT_WC_OFF, `DFMC_FT_PWR_OFF, `DFMC_FT_PUIS_OFF, `DFMC_FT_OFS_OFF,
            `DFMC_FT_RLA_ON, `DFMC_FT_ECC4, `DFMC_FT_ACU_OFF, `DFMC_FT_REV_ON,
            `DFMC_FT_RELI_OFF: abort_d = 1'b0;
            default:         abort_d = 1'b1;
         endcase
      end
      else if (max_set)
      begin
         if (max_state_out != DFMC_MAX_UNLOCKED)
            abort_d = 1'b1;
         else if (sc[`DFMC_SC_NV_BIT] && (address_offset_out || nv_done_q))
            abort_d = 1'b1;
         else if (req_lba > `DFMC_NATIVE_MAX)
            abort_d = 1'b1;
      end
      else if (max_cmd)
      begin
         unique case (feature_in)
            8'h01, 8'h02: abort_d = (max_state_out != DFMC_MAX_UNLOCKED);
            8'h03:        abort_d = (max_state_out == DFMC_MAX_FROZEN);
            8'h04:        abort_d = (max_state_out == DFMC_MAX_FROZEN);
            default:      abort_d = 1'b1;
         endcase
      end
      else if (cmd_wr_in && (cmd_in == `DFMC_CMD_SERVICE))
         abort_d = !released_pending_in;
   end
   // ---------------------------------------------------------
   // Error and status registers, drive select echo
   // ---------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         error_flags_out  <= 8'h00;
         status_flags_out <= 8'h50;
      end
      else if (cmd_wr_in)
      begin
         error_flags_out <= 8'h00;
         error_flags_out[`DFMC_ERR_ABT_BIT] <= abort_d;
         status_flags_out <= 8'h50;
         status_flags_out[`DFMC_STS_ERR_BIT] <= abort_d;
      end
   end
   // Only the drive-select bit is taken for Service
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         drive_and_head_select_out <= 8'h00;
      else if (cmd_wr_in && (cmd_in == `DFMC_CMD_SERVICE))
         drive_and_head_select_out <= {3'b000, drive_and_head_select_in[`DFMC_DH_DEV_BIT], 4'h0};
      else if (max_set && !abort_d)
         drive_and_head_select_out <= {4'h0, req_lba[27:24]};
   end
   // One-cycle request to resume the released command
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         service_req_out <= 1'b0;
      else
         service_req_out <= cmd_wr_in && (cmd_in == `DFMC_CMD_SERVICE) && released_pending_in;
   end
   // ---------------------------------------------------------
   // Features restored at hard reset; cache, ECC and look-ahead also at soft reset unless kept
   // ---------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         wc_req_q            <= 1'b1;
         ecc40_out           <= 1'b0;
         read_ahead_out      <= 1'b1;
         revert_defaults_out <= 1'b0;
         release_irq_out     <= 1'b0;
         no_ready_out        <= 1'b0;
         xfer_mode_out       <= 8'h00;
         address_offset_out  <= 1'b0;
         standby_powerup_out <= 1'b0;
      end
      else if (soft_rst_in && revert_defaults_out)
      begin
         wc_req_q       <= 1'b1;
         ecc40_out      <= 1'b0;
         read_ahead_out <= 1'b1;
      end
      else if (fe_cmd && !abort_d)
      begin
         unique case (feature_in)
            `DFMC_FT_WC_ON:    wc_req_q            <= 1'b1;
            `DFMC_FT_WC_OFF:   wc_req_q            <= 1'b0;
            `DFMC_FT_RLA_ON:   read_ahead_out      <= 1'b1;
            `DFMC_FT_RLA_OFF:  read_ahead_out      <= 1'b0;
            `DFMC_FT_ECC40:    ecc40_out           <= 1'b1;
            `DFMC_FT_ECC4:     ecc40_out           <= 1'b0;
            `DFMC_FT_REV_ON:   revert_defaults_out <= 1'b1;
            `DFMC_FT_REV_OFF:  revert_defaults_out <= 1'b0;
            `DFMC_FT_RELI_ON:  release_irq_out     <= 1'b1;
            `DFMC_FT_RELI_OFF: release_irq_out     <= 1'b0;
            `DFMC_FT_OFS_ON:   address_offset_out  <= 1'b1;
            `DFMC_FT_OFS_OFF:  address_offset_out  <= 1'b0;
            `DFMC_FT_PUIS_ON:  standby_powerup_out <= 1'b1;
            `DFMC_FT_PUIS_OFF: standby_powerup_out <= 1'b0;
            `DFMC_FT_XFER:
            begin
               xfer_mode_out <= sc;
               no_ready_out  <= xfer_no_ready;
            end
            default: ;
         endcase
      end
   end
   // Reassignment exhaustion overrides the cache request
   assign write_cache_out = wc_req_q && !reassign_full;
   // ---------------------------------------------------------
   // Advanced power management
   // ---------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         power_level_control_out <= 1'b0;
         deepest_power_out       <= DFMC_PWR_IDLE;
      end
      else if (fe_cmd && !abort_d && (feature_in == `DFMC_FT_PWR_ON))
      begin
         power_level_control_out <= 1'b1;
         deepest_power_out <= sc[7] ? DFMC_PWR_LPIDLE : DFMC_PWR_LOWRPM;
      end
      else if (fe_cmd && (feature_in == `DFMC_FT_PWR_OFF))
      begin
         power_level_control_out <= 1'b0;
         deepest_power_out       <= DFMC_PWR_IDLE;
      end
   end
   // Head and spindle targets for the deepest saving state
   assign heads_unload_out = (deepest_power_out != DFMC_PWR_IDLE);
   assign spindle_pct_out  = (deepest_power_out == DFMC_PWR_LOWRPM) ?
                             `DFMC_SPIN_LOW_PCT : `DFMC_SPIN_FULL_PCT;
   // ---------------------------------------------------------
   // Acoustic management, kept through every reset but power-on
   // ---------------------------------------------------------
   logic [7:0] acu_level_q;
   always_ff @(posedge clk_in)
   begin
      if (por_in)
      begin
         acoustic_level_control_out <= 1'b0;
         acu_level_q                <= `DFMC_ACU_RST;
      end
      else if (fe_cmd && !abort_d && (feature_in == `DFMC_FT_ACU_ON))
      begin
         acoustic_level_control_out <= 1'b1;
         acu_level_q                <= sc;
      end
      else if (fe_cmd && (feature_in == `DFMC_FT_ACU_OFF))
         acoustic_level_control_out <= 1'b0;
   end
   // Quiet seek for levels 80-BF while enabled
   assign quiet_seek_out = acoustic_level_control_out && (acu_level_q < 8'hC0);
   // ---------------------------------------------------------
   // Max address limit: nonvolatile copy survives power-on
   // ---------------------------------------------------------
   logic [27:0] nv_max_q;
   always_ff @(posedge clk_in)
   begin
      if (max_set && !abort_d && sc[`DFMC_SC_NV_BIT])
         nv_max_q <= req_lba;
      else if (por_in && (nv_max_q > `DFMC_NATIVE_MAX))
         nv_max_q <= `DFMC_NATIVE_MAX;
   end
   // Power-on reloads the persistent limit, dropping volatile ones
   always_ff @(posedge clk_in)
   begin
      if (por_in)
         max_lba_out <= (nv_max_q > `DFMC_NATIVE_MAX) ? `DFMC_NATIVE_MAX : nv_max_q;
      else if (max_set && !abort_d)
         max_lba_out <= req_lba;
   end
   // Accesses past the limit are aborted
   assign access_abort_out = access_chk_in && (access_lba_in > max_lba_out);
   // One nonvolatile set per hard reset
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         nv_done_q <= 1'b0;
      else if (max_set && !abort_d && sc[`DFMC_SC_NV_BIT])
         nv_done_q <= 1'b1;
   end
   // Remember a preceding read-native-max command
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         native_seen_q <= 1'b0;
      else if (cmd_wr_in)
         native_seen_q <= (cmd_in == `DFMC_CMD_READ_NATIVE);
   end
   // Security extension state
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         max_state_out <= DFMC_MAX_UNLOCKED;
      else if (max_cmd && !max_set && !abort_d)
      begin
         unique case (feature_in)
            8'h02:   max_state_out <= DFMC_MAX_LOCKED;
            8'h03:   max_state_out <= DFMC_MAX_UNLOCKED;
            8'h04:   max_state_out <= DFMC_MAX_FROZEN;
            default: ;
         endcase
      end
   end
endmodule

// ==== rtl/dfmc_regs.svh ====
// Constants for the feature and max-address command block.
// Assumes inclusion by the core and decoder design modules only.
`ifndef DFMC_REGS_SVH
`define DFMC_REGS_SVH
// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define DFMC_CMD_SERVICE      8'hA2
`define DFMC_CMD_SET_FEATURES 8'hEF
`define DFMC_CMD_SET_MAX      8'hF9
`define DFMC_CMD_READ_NATIVE  8'hF8
// ------------------------------------------------------------
// Feature codes
// ------------------------------------------------------------
`define DFMC_FT_WC_ON    8'h02
`define DFMC_FT_XFER     8'h03
`define DFMC_FT_PWR_ON   8'h05
`define DFMC_FT_PUIS_ON  8'h06
`define DFMC_FT_PUIS_SPN 8'h07
`define DFMC_FT_OFS_ON   8'h09
`define DFMC_FT_ACU_ON   8'h42
`define DFMC_FT_ECC40    8'h44
`define DFMC_FT_RLA_OFF  8'h55
`define DFMC_FT_RELI_ON  8'h5D
`define DFMC_FT_REV_OFF  8'h66
`define DFMC_FT_WC_OFF   8'h82
`define DFMC_FT_PWR_OFF  8'h85
`define DFMC_FT_PUIS_OFF 8'h86
`define DFMC_FT_OFS_OFF  8'h89
`define DFMC_FT_RLA_ON   8'hAA
`define DFMC_FT_ECC4     8'hBB
`define DFMC_FT_ACU_OFF  8'hC2
`define DFMC_FT_REV_ON   8'hCC
`define DFMC_FT_RELI_OFF 8'hDD
// ------------------------------------------------------------
// Transfer type selectors (upper five bits) and top modes
// ------------------------------------------------------------
`define DFMC_XT_PIO_DEF  5'b00000
`define DFMC_XT_PIO_FC   5'b00001
`define DFMC_XT_MWDMA    5'b00100
`define DFMC_XT_UDMA     5'b01000
`define DFMC_XM_PIO_MAX  3'b100
`define DFMC_XM_MW_MAX   3'b010
`define DFMC_XM_UD_MAX   3'b101
// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define DFMC_ERR_ABT_BIT 2
`define DFMC_STS_BSY_BIT 7
`define DFMC_STS_RDY_BIT 6
`define DFMC_STS_DSC_BIT 4
`define DFMC_STS_ERR_BIT 0
`define DFMC_DH_LBA_BIT  6
`define DFMC_DH_DEV_BIT  4
`define DFMC_SC_NV_BIT   0
`define DFMC_ACU_RST     8'hFE
`define DFMC_PWR_RST     8'h80
`define DFMC_NATIVE_MAX  28'h0FF_FFFF
`define DFMC_SPIN_LOW_PCT 7'd62
`define DFMC_SPIN_FULL_PCT 7'd100
`endif

// ==== rtl/dfmc_pkg.sv ====
// Types for the feature and max-address command block.
// Assumes the constants header sits beside it.
package dfmc_pkg;
   typedef enum logic [1:0]
   {
      DFMC_PWR_IDLE   = 2'b00,
      DFMC_PWR_LPIDLE = 2'b01,
      DFMC_PWR_LOWRPM = 2'b10
   } dfmc_pwr_type;
   typedef enum logic [1:0]
   {
      DFMC_MAX_UNLOCKED = 2'b00,
      DFMC_MAX_LOCKED   = 2'b01,
      DFMC_MAX_FROZEN   = 2'b10
   } dfmc_max_type;
endpackage

// ==== rtl/dfmc_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes one clock; output changes once stages two and three agree.
`timescale 1ns/1ns
module dfmc_sync
   import dfmc_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic pin_in,
   output logic      level_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // ---------------------------------------------------------
   // Synchroniser chain
   // ---------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // Take the value only when the last two stages agree
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         level_out <= 1'b0;
      else if (s2_q == s3_q)
         level_out <= s3_q;
   end
endmodule

// ==== rtl/dfmc_xfer_decode.sv ====
// Decoder for the transfer-mode selector in the sector count.
// Assumes a stable selector; purely combinational.
`timescale 1ns/1ns
`include "dfmc_regs.svh"
module dfmc_xfer_decode
   import dfmc_pkg::*;
(
   input  wire logic [7:0] sel_in,
   output logic            valid_out,
   output logic            no_ready_out
);
   logic [4:0] xtype;
   logic [2:0] xmode;
   // Split selector into type and mode number
   assign xtype = sel_in[7:3];
   assign xmode = sel_in[2:0];
   // Check the mode number against each type's range
   always_comb
   begin
      valid_out    = 1'b0;
      no_ready_out = 1'b0;
      unique case (xtype)
         `DFMC_XT_PIO_DEF:
         begin
            valid_out    = (xmode <= 3'b001);
            no_ready_out = (xmode == 3'b001);
         end
         `DFMC_XT_PIO_FC: valid_out = (xmode <= `DFMC_XM_PIO_MAX);
         `DFMC_XT_MWDMA:  valid_out = (xmode <= `DFMC_XM_MW_MAX);
         `DFMC_XT_UDMA:   valid_out = (xmode <= `DFMC_XM_UD_MAX);
         default:         valid_out = 1'b0;
      endcase
   end
endmodule

// ==== verification/dfmc_props.sv ====
// Checker for the feature, service and max-address command block.
// Assumes it is bound onto dfmc_core; one clock, active-low reset.
`timescale 1ns/1ns
module dfmc_props
   import dfmc_pkg::*;
(
   input wire logic         clk_in,
   input wire logic         rst_b_in,
   input wire logic         cmd_wr_in,
   input wire logic [7:0]   cmd_in,
   input wire logic [7:0]   feature_in,
   input wire logic         released_pending_in,
   input wire logic         reassign_full_pin_in,
   input wire logic         access_chk_in,
   input wire logic [27:0]  access_lba_in,
   input wire logic [7:0]   error_flags_out,
   input wire logic [7:0]   status_flags_out,
   input wire logic         service_req_out,
   input wire logic         access_abort_out,
   input wire logic [27:0]  max_lba_out,
   input wire logic         write_cache_out,
   input wire logic         read_ahead_out,
   input wire logic         ecc40_out,
   input wire logic         power_level_control_out,
   input wire dfmc_pwr_type deepest_power_out,
   input wire logic         heads_unload_out,
   input wire logic [6:0]   spindle_pct_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // Command strobes as named steps
   sequence ft_s(logic [7:0] f);
      cmd_wr_in && cmd_in == 8'hEF && feature_in == f;
   endsequence
   sequence svc_s;
      cmd_wr_in && cmd_in == 8'hA2 && released_pending_in;
   endsequence
   // Command effects one cycle after the strobe, with head, cache and limit checks
   undef_code_a: assert property (ft_s(8'h00) |=> error_flags_out[2] && status_flags_out[0])
      else $error("undefined feature not aborted");
   ahead_on_a: assert property (ft_s(8'hAA) |=> read_ahead_out && !error_flags_out[2])
      else $error("look-ahead not enabled");
   pwr_off_a: assert property (ft_s(8'h85) |=> !power_level_control_out && deepest_power_out == DFMC_PWR_IDLE)
      else $error("power management not off");
   ecc_long_a: assert property (ft_s(8'h44) |=> ecc40_out ##0 !error_flags_out[2])
      else $error("long correction not selected");
   head_unload_a: assert property (heads_unload_out == (deepest_power_out != DFMC_PWR_IDLE) &&
      (spindle_pct_out inside {[7'd60:7'd65]}) == (deepest_power_out == DFMC_PWR_LOWRPM))
      else $error("head unload or spindle speed mismatch");
   svc_pulse_a: assert property (svc_s |=> service_req_out && !error_flags_out[2])
      else $error("service not delivered");
   cache_full_a: assert property (reassign_full_pin_in [*6] |=> !write_cache_out)
      else $error("write cache not forced off");
   limit_abort_a: assert property (access_chk_in |-> access_abort_out == (access_lba_in > max_lba_out))
      else $error("access limit mismatch");
endmodule
bind dfmc_core dfmc_props u_props (.clk_in, .rst_b_in, .cmd_wr_in, .cmd_in, .feature_in, .released_pending_in,
   .reassign_full_pin_in, .access_chk_in, .access_lba_in, .error_flags_out, .status_flags_out,
   .service_req_out, .access_abort_out, .max_lba_out, .write_cache_out, .read_ahead_out, .ecc40_out,
   .power_level_control_out, .deepest_power_out, .heads_unload_out, .spindle_pct_out);

// ==== verification/dfmc_host.sv ====
// Host controller model writing the task file, then strobing the command.
// Assumes the bench calls issue; busy never rises in this block.
`timescale 1ns/1ns
module dfmc_host
(
   input  wire logic  clk_in,
   output logic       cmd_wr_out,
   output logic [7:0] cmd_out,
   output logic [7:0] feature_out,
   output logic [7:0] sector_count_out,
   output logic [31:0] addr_out
);
   // Quiet task file before the first command
   initial
   begin
      cmd_wr_out = 1'b0;
      {cmd_out, feature_out, sector_count_out} = 24'h00_0000;
      addr_out = 32'hA000_0000;
   end
   // Registers and strobe set at the same falling edge, strobe dropped at the next one
   task automatic issue(input logic [7:0] c, f, s, input logic [31:0] a);
      @(negedge clk_in);
      feature_out = f;
      sector_count_out = s;
      addr_out = a;
      cmd_out = c;
      cmd_wr_out = 1'b1;
      @(negedge clk_in);
      cmd_wr_out = 1'b0;
   endtask
endmodule

// ==== verification/tb_drive_feature_maxaddr_cmds.sv ====
// Bench for the command block: features, service and max-address limits.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ns
module tb_drive_feature_maxaddr_cmds
   import dfmc_pkg::*;
;
   logic         clk_in, rst_b_in, soft_rst_in, por_in, full_in, pend_in, chk_in, cmd_wr;
   logic         svc, abrt, wc, ra, ecc, rev, rel, acu, quiet, nrdy;
   logic [27:0]  lba_in, max_lba;
   logic [31:0]  adr;
   logic [7:0]   err, sts, dh_o, cmd, ft, sc, xm;
   dfmc_pwr_type deep;
   dfmc_max_type mst;
   int           n_errors = 0;
   int           total_checks = 0;
   logic [19:0]  ft_tab [33] = '{20'hA_A000, 20'h5_5000, 20'h0_5800, 20'h0_5400, 20'h0_5C01, 20'h0_53F1,
      20'h8_5000, 20'h4_4000, 20'hB_B000, 20'h4_2C00, 20'h4_2FF1, 20'h4_27F1, 20'h4_2800, 20'h0_0001,
      20'h0_3000, 20'h0_3010, 20'h0_30C0, 20'h0_30D1, 20'h0_3220, 20'h0_3231, 20'h0_3450, 20'h0_3461,
      20'h0_3101, 20'h0_6000, 20'h0_7000, 20'h8_6000, 20'h5_D000, 20'h8_2000, 20'h8_9000, 20'hC_2000,
      20'h6_6000, 20'hC_C000, 20'hD_D000};
   dfmc_host u_host (.clk_in, .cmd_wr_out(cmd_wr), .cmd_out(cmd), .feature_out(ft), .sector_count_out(sc),
      .addr_out(adr));
   dfmc_core dut (.clk_in, .rst_b_in, .soft_rst_in, .por_in, .cmd_wr_in(cmd_wr), .cmd_in(cmd), .feature_in(ft),
      .sector_count_in(sc), .sector_number_in(adr[7:0]), .cyl_low_in(adr[15:8]), .cyl_high_in(adr[23:16]),
      .drive_and_head_select_in(adr[31:24]), .reassign_full_pin_in(full_in), .access_chk_in(chk_in),
      .access_lba_in(lba_in), .released_pending_in(pend_in), .error_flags_out(err), .status_flags_out(sts),
      .drive_and_head_select_out(dh_o), .service_req_out(svc), .access_abort_out(abrt), .max_lba_out(max_lba),
      .write_cache_out(wc), .read_ahead_out(ra), .ecc40_out(ecc), .revert_defaults_out(rev),
      .release_irq_out(rel), .no_ready_out(nrdy), .xfer_mode_out(xm), .power_level_control_out(),
      .deepest_power_out(deep), .heads_unload_out(), .spindle_pct_out(), .acoustic_level_control_out(acu),
      .quiet_seek_out(quiet), .address_offset_out(), .standby_powerup_out(), .max_state_out(mst));
   // Free-running 100 MHz clock
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One command and its flag answer; ab is the expected abort
   task automatic run(input logic [7:0] c, f, s, input logic [31:0] a, input logic ab);
      u_host.issue(c, f, s, a);
      chk(err, {5'h00, ab, 2'h0});
      chk(sts, {4'h5, 3'h0, ab});
   endtask
   task automatic nat;
      u_host.issue(8'hF8, 8'h00, 8'h00, 32'hE000_0000);
   endtask
   task automatic pulse(ref logic p);
      @(negedge clk_in);
      p = 1'b1;
      @(negedge clk_in);
      p = 1'b0;
   endtask
   task automatic hard_rst;
      @(negedge clk_in);
      rst_b_in = 1'b0;
      repeat (10) @(negedge clk_in);
      rst_b_in = 1'b1;
   endtask
   task automatic dflt;
      chk({wc, ra, ecc, rev, rel}, 5'h18);
   endtask
   task automatic final_report;
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      #100000;
      n_errors++;
      final_report();
   end
   // Test sequence
   initial
   begin
      {rst_b_in, soft_rst_in, por_in, full_in, pend_in, chk_in} = 6'h00;
      lba_in = 28'h000_0000;
      repeat (10) @(negedge clk_in);
      rst_b_in = 1'b1;
      pulse(por_in);
      dflt();
      foreach (ft_tab[i])
         run(8'hEF, ft_tab[i][19:12], ft_tab[i][11:4], 32'hA000_0000, ft_tab[i][0]);
      chk({ra, ecc, rev, quiet}, 4'h2);
      chk({nrdy, xm}, 9'h045);
      run(8'hEF, 8'h05, 8'h40, 32'hA000_0000, 1'b0);
      chk(deep, DFMC_PWR_LOWRPM);
      run(8'hEF, 8'h05, 8'hBF, 32'hA000_0000, 1'b0);
      chk(deep, DFMC_PWR_LPIDLE);
      pend_in = 1'b1;
      run(8'hA2, 8'h00, 8'h00, 32'hB000_0000, 1'b0);
      chk({svc, dh_o[4]}, 2'h3);
      pend_in = 1'b0;
      run(8'hA2, 8'h00, 8'h00, 32'hB000_0000, 1'b1);
      full_in = 1'b1;
      repeat (8) @(negedge clk_in);
      run(8'hEF, 8'h02, 8'h00, 32'hA000_0000, 1'b0);
      chk(wc, 1'b0);
      full_in = 1'b0;
      run(8'hEF, 8'h42, 8'h80, 32'hA000_0000, 1'b0);
      pulse(soft_rst_in);
      chk({ra, quiet, acu}, 3'h7);
      hard_rst();
      chk({quiet, acu}, 2'h3);
      dflt();
      nat();
      run(8'hF9, 8'h00, 8'h01, 32'hE000_2000, 1'b0);
      chk(max_lba, 28'h000_2000);
      @(negedge clk_in);
      chk_in = 1'b1;
      lba_in = 28'h000_2001;
      #1 chk(abrt, 1'b1);
      @(negedge clk_in);
      lba_in = 28'h000_2000;
      #1 chk(abrt, 1'b0);
      @(negedge clk_in);
      chk_in = 1'b0;
      nat();
      run(8'hF9, 8'h00, 8'h01, 32'hE000_3000, 1'b1);
      nat();
      run(8'hF9, 8'h00, 8'h00, 32'hE000_1000, 1'b0);
      chk(max_lba, 28'h000_1000);
      pulse(por_in);
      chk(max_lba, 28'h000_2000);
      hard_rst();
      run(8'hEF, 8'h09, 8'h00, 32'hA000_0000, 1'b0);
      nat();
      run(8'hF9, 8'h00, 8'h01, 32'hE000_3000, 1'b1);
      run(8'hEF, 8'h89, 8'h00, 32'hA000_0000, 1'b0);
      nat();
      run(8'hF9, 8'h00, 8'h01, 32'hE100_3000, 1'b1);
      nat();
      run(8'hF9, 8'h00, 8'h01, 32'hE000_3000, 1'b0);
      chk({dh_o[3:0], max_lba}, 32'h0000_3000);
      run(8'hF9, 8'h02, 8'h00, 32'hA000_0000, 1'b0);
      chk(mst, DFMC_MAX_LOCKED);
      nat();
      run(8'hF9, 8'h00, 8'h00, 32'hE000_1000, 1'b1);
      run(8'hF9, 8'h03, 8'h00, 32'hA000_0000, 1'b0);
      run(8'hF9, 8'h04, 8'h00, 32'hA000_0000, 1'b0);
      chk(mst, DFMC_MAX_FROZEN);
      nat();
      run(8'hF9, 8'h00, 8'h00, 32'hE000_1000, 1'b1);
      run(8'hF9, 8'h03, 8'h00, 32'hA000_0000, 1'b1);
      run(8'hF9, 8'h05, 8'h00, 32'hA000_0000, 1'b1);
      final_report();
   end
endmodule
